// [inc/dacrb_pkg.sv]
// Constants and types of the four-channel readback two-wire slave
package dacrb_pkg;

  // ****************************************
  // Addressing and register map
  // ****************************************
  localparam logic [4:0]  DEV_ADDR_FIXED = 5'h13;
  localparam logic [7:0]  OFS_CFG        = 8'h00;
  localparam logic [7:0]  OFS_CHWR       = 8'h04;
  localparam logic [7:0]  OFS_STAT       = 8'h08;
  localparam logic [2:0]  CFG_RESET      = 3'h0;
  localparam logic [13:0] CHAN_RESET     = 14'h0000;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int CTRL_PD_POS  = 0;
  localparam int CTRL_SEL_LO  = 1;
  localparam int CTRL_LOAD_LO = 4;
  localparam int CW_CHAN_LO   = 16;
  localparam int CW_PD_POS    = 18;
  localparam int CFG_EN_POS   = 0;
  localparam int CFG_ADDR_LO  = 1;

  // ****************************************
  // Readback framing
  // ****************************************
  localparam logic [1:0] LEN_NORMAL = 2'h2;
  localparam logic [1:0] LEN_PD     = 2'h3;
  localparam logic [5:0] PD_FILL    = 6'h3f;
  localparam logic [3:0] LOW_FILL   = 4'h0;
  localparam logic [3:0] BITS_BYTE  = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RECV = 3'b001,
    ST_ACK  = 3'b010,
    ST_SEND = 3'b011,
    ST_MACK = 3'b100
  } dacrb_state_type;

endpackage : dacrb_pkg

// [inc/dacrb_mem_if.sv]
// Channel register access between the slave logic and the register store
`timescale 1ns/10ps
`default_nettype none
interface dacrb_mem_if;
  logic        wr_en;
  logic [1:0]  wr_chan;
  logic [13:0] wr_data;
  logic        wr_top_only;
  logic        rd_en;
  logic [1:0]  rd_chan;
  logic [13:0] rd_data;
  logic        rd_valid;
  modport ctl (output wr_en, wr_chan, wr_data, wr_top_only, rd_en, rd_chan,
               input rd_data, rd_valid);
  modport mem (input wr_en, wr_chan, wr_data, wr_top_only, rd_en, rd_chan,
               output rd_data, rd_valid);
endinterface : dacrb_mem_if
`default_nettype wire

// [rtl/dacrb_chan_mem.sv]
// Temporary and channel registers of the four channels
`timescale 1ns/10ps
`default_nettype none
module dacrb_chan_mem (
  // Clock and reset
  input  wire logic hclk,
  input  wire logic hresetn,
  // Access port
  dacrb_mem_if.mem  m
);

  logic [13:0] temp_channel_reg [4];
  logic [13:0] dac_channel_reg  [4];

  // ****************************************
  // Storage
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int i = 0; i < 4; i++) begin
        temp_channel_reg[i] <= dacrb_pkg::CHAN_RESET;
        dac_channel_reg[i]  <= dacrb_pkg::CHAN_RESET;
      end
    end else if (m.wr_en) begin
      if (m.wr_top_only) begin
        temp_channel_reg[m.wr_chan][13:12] <= m.wr_data[13:12];
        dac_channel_reg[m.wr_chan][13:12]  <= m.wr_data[13:12];
      end else begin
        temp_channel_reg[m.wr_chan] <= m.wr_data;
        dac_channel_reg[m.wr_chan]  <= m.wr_data;
      end
    end
  end

  // ****************************************
  // Registered read
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      m.rd_data  <= dacrb_pkg::CHAN_RESET;
      m.rd_valid <= 1'b0;
    end else begin
      m.rd_valid <= m.rd_en;
      if (m.rd_en) begin
        m.rd_data <= dac_channel_reg[m.rd_chan];
      end
    end
  end

endmodule : dacrb_chan_mem
`default_nettype wire

// [rtl/dacrb_top.sv]
// Two-wire readback slave with register bus and channel store
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module dacrb_top #(
  parameter int BUF_WIDTH = 8
) (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Register bus
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Two-wire bus
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe
);

  // ****************************************
  // Elaboration check
  // ****************************************
  if (BUF_WIDTH < 8) begin : g_bad_width
    $error("BUF_WIDTH must hold a whole byte");
  end

  // ****************************************
  // Declarations
  // ****************************************
  dacrb_mem_if             mif ();
  dacrb_pkg::dacrb_state_type state;
  logic                    scl_m;
  logic                    scl_s;
  logic                    scl_d;
  logic                    sda_m;
  logic                    sda_s;
  logic                    sda_d;
  logic                    scl_rise;
  logic                    scl_fall;
  logic                    bus_start;
  logic                    bus_stop;
  logic [2:0]              cfg;
  logic [3:0]              bit_cnt;
  logic [7:0]              shreg;
  logic [7:0]              txbyte;
  logic [7:0]              ctrl_byte;
  logic                    role_ctrl;
  logic                    is_read;
  logic [1:0]              tx_left;
  logic                    start_rd;
  logic                    addr_ok;
  logic [1:0]              prod_idx;
  logic [1:0]              prod_total;
  logic                    prod_act;
  logic [13:0]             prod_word;
  logic [BUF_WIDTH-1:0]    buf_q [2];
  logic [1:0]              buf_cnt;
  logic                    in_valid;
  logic                    in_ready;
  logic                    out_valid;
  logic                    out_ready;
  logic [BUF_WIDTH-1:0]    out_data;
  logic [BUF_WIDTH-1:0]    in_data;
  logic                    ap_wr;
  logic [7:0]              ap_addr;

  // ****************************************
  // Readback byte selection
  // ****************************************
  function automatic logic [7:0] rb_byte(input logic [1:0] idx, input logic pd,
                                         input logic [13:0] w);
    logic [1:0] k;
    k = pd ? idx : 2'(idx + 2'h1);
    case (k)
      2'h0:    rb_byte = {w[13:12], dacrb_pkg::PD_FILL};
      2'h1:    rb_byte = w[11:4];
      default: rb_byte = {w[3:0], dacrb_pkg::LOW_FILL};
    endcase
  endfunction : rb_byte

  // ****************************************
  // Pin synchronisers and bus events
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_m <= scl_i;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= sda_i;
      sda_s <= sda_m;
      sda_d <= sda_s;
    end
  end

  assign scl_rise  = scl_s & ~scl_d;
  assign scl_fall  = ~scl_s & scl_d;
  assign bus_start = cfg[dacrb_pkg::CFG_EN_POS] & scl_s & scl_d & sda_d & ~sda_s;
  assign bus_stop  = scl_s & scl_d & ~sda_d & sda_s;
  assign addr_ok   = shreg[7:1] == {dacrb_pkg::DEV_ADDR_FIXED,
                                    cfg[dacrb_pkg::CFG_ADDR_LO +: 2]};
  assign out_ready = (state == dacrb_pkg::ST_ACK && scl_fall && is_read && !role_ctrl)
                   | (state == dacrb_pkg::ST_MACK && scl_fall && tx_left != 2'h0);

  // ****************************************
  // Protocol state machine
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state     <= dacrb_pkg::ST_IDLE;
      bit_cnt   <= 4'h0;
      shreg     <= 8'h00;
      txbyte    <= 8'h00;
      ctrl_byte <= 8'h00;
      role_ctrl <= 1'b0;
      is_read   <= 1'b0;
      tx_left   <= 2'h0;
      start_rd  <= 1'b0;
      sda_oe    <= 1'b0;
    end else begin
      start_rd <= 1'b0;
      if (bus_start) begin
        state     <= dacrb_pkg::ST_RECV;
        bit_cnt   <= 4'h0;
        role_ctrl <= 1'b0;
        sda_oe    <= 1'b0;
      end else if (bus_stop) begin
        state  <= dacrb_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else begin
        case (state)
          dacrb_pkg::ST_RECV: begin
            if (scl_rise && bit_cnt != dacrb_pkg::BITS_BYTE) begin
              shreg   <= {shreg[6:0], sda_s};
              bit_cnt <= 4'(bit_cnt + 4'h1);
            end else if (scl_fall && bit_cnt == dacrb_pkg::BITS_BYTE) begin
              if (role_ctrl) begin
                ctrl_byte <= shreg;
                sda_oe    <= 1'b1;
                state     <= dacrb_pkg::ST_ACK;
              end else if (addr_ok) begin
                is_read <= shreg[0];
                sda_oe  <= 1'b1;
                state   <= dacrb_pkg::ST_ACK;
                if (shreg[0]) begin
                  start_rd <= 1'b1;
                  tx_left  <= ctrl_byte[dacrb_pkg::CTRL_PD_POS] ?
                              dacrb_pkg::LEN_PD : dacrb_pkg::LEN_NORMAL;
                end
              end else begin
                state <= dacrb_pkg::ST_IDLE;
              end
            end
          end
          dacrb_pkg::ST_ACK: begin
            if (scl_fall) begin
              bit_cnt <= 4'h0;
              if (role_ctrl) begin
                sda_oe <= 1'b0;
                state  <= dacrb_pkg::ST_IDLE;
              end else if (is_read) begin
                txbyte  <= out_valid ? out_data[7:0] : 8'hff;
                sda_oe  <= out_valid & ~out_data[7];
                tx_left <= 2'(tx_left - 2'h1);
                state   <= dacrb_pkg::ST_SEND;
              end else begin
                sda_oe    <= 1'b0;
                role_ctrl <= 1'b1;
                state     <= dacrb_pkg::ST_RECV;
              end
            end
          end
          dacrb_pkg::ST_SEND: begin
            if (scl_fall) begin
              if (bit_cnt == 4'h7) begin
                sda_oe <= 1'b0;
                state  <= dacrb_pkg::ST_MACK;
              end else begin
                txbyte  <= {txbyte[6:0], 1'b1};
                sda_oe  <= ~txbyte[6];
                bit_cnt <= 4'(bit_cnt + 4'h1);
              end
            end
          end
          dacrb_pkg::ST_MACK: begin
            if (scl_rise && (sda_s || tx_left == 2'h0)) begin
              state <= dacrb_pkg::ST_IDLE;
            end else if (scl_fall) begin
              bit_cnt <= 4'h0;
              txbyte  <= out_valid ? out_data[7:0] : 8'hff;
              sda_oe  <= out_valid & ~out_data[7];
              tx_left <= 2'(tx_left - 2'h1);
              state   <= dacrb_pkg::ST_SEND;
            end
          end
          dacrb_pkg::ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          default: begin
            state  <= dacrb_pkg::ST_IDLE;
            sda_oe <= 1'b0;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Readback byte producer
  // ****************************************
  assign mif.rd_en   = start_rd;
  assign mif.rd_chan = ctrl_byte[dacrb_pkg::CTRL_SEL_LO +: 2];
  assign in_valid    = prod_act;
  assign in_data     = BUF_WIDTH'(rb_byte(prod_idx, ctrl_byte[dacrb_pkg::CTRL_PD_POS],
                                          prod_word));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      prod_idx   <= 2'h0;
      prod_total <= 2'h0;
      prod_act   <= 1'b0;
      prod_word  <= dacrb_pkg::CHAN_RESET;
    end else if (start_rd) begin
      prod_idx   <= 2'h0;
      prod_act   <= 1'b0;
      prod_total <= ctrl_byte[dacrb_pkg::CTRL_PD_POS] ?
                    dacrb_pkg::LEN_PD : dacrb_pkg::LEN_NORMAL;
    end else if (mif.rd_valid) begin
      prod_word <= mif.rd_data;
      prod_act  <= 1'b1;
    end else if (prod_act && in_ready) begin
      prod_idx <= 2'(prod_idx + 2'h1);
      if (prod_idx == 2'(prod_total - 2'h1)) begin
        prod_act <= 1'b0;
      end
    end
  end

  // ****************************************
  // Two-entry byte buffer
  // ****************************************
  assign in_ready  = buf_cnt != 2'h2;
  assign out_valid = buf_cnt != 2'h0;
  assign out_data  = buf_q[0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buf_cnt  <= 2'h0;
      buf_q[0] <= '0;
      buf_q[1] <= '0;
    end else if (start_rd) begin
      buf_cnt <= 2'h0;
    end else begin
      case ({in_valid && in_ready, out_ready && out_valid})
        2'b10: begin
          buf_q[buf_cnt[0]] <= in_data;
          buf_cnt           <= 2'(buf_cnt + 2'h1);
        end
        2'b01: begin
          buf_q[0] <= buf_q[1];
          buf_cnt  <= 2'(buf_cnt - 2'h1);
        end
        2'b11: begin
          if (buf_cnt == 2'h1) begin
            buf_q[0] <= in_data;
          end else begin
            buf_q[0] <= buf_q[1];
            buf_q[1] <= in_data;
          end
        end
        default: begin
          buf_cnt <= buf_cnt;
        end
      endcase
    end
  end

  // ****************************************
  // Register bus slave
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_wr     <= 1'b0;
      ap_addr   <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      ap_wr <= 1'b0;
      if (hsel && htrans[1] && hready) begin
        ap_wr   <= hwrite;
        ap_addr <= haddr[7:0];
        hrdata  <= 32'h0000_0000;
        if (!hwrite) begin
          case (haddr[7:0])
            dacrb_pkg::OFS_CFG:  hrdata <= {29'h0000_0000, cfg};
            dacrb_pkg::OFS_STAT: hrdata <= {16'h0000, ctrl_byte, 2'h0, buf_cnt,
                                            tx_left != 2'h0, state};
            default:             hrdata <= 32'h0000_0000;
          endcase
        end
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg             <= dacrb_pkg::CFG_RESET;
      mif.wr_en       <= 1'b0;
      mif.wr_chan     <= 2'h0;
      mif.wr_data     <= dacrb_pkg::CHAN_RESET;
      mif.wr_top_only <= 1'b0;
    end else begin
      mif.wr_en <= 1'b0;
      if (ap_wr && ap_addr == dacrb_pkg::OFS_CFG) begin
        cfg <= hwdata[2:0];
      end
      if (ap_wr && ap_addr == dacrb_pkg::OFS_CHWR) begin
        mif.wr_en       <= 1'b1;
        mif.wr_chan     <= hwdata[dacrb_pkg::CW_CHAN_LO +: 2];
        mif.wr_top_only <= hwdata[dacrb_pkg::CW_PD_POS];
        mif.wr_data     <= hwdata[dacrb_pkg::CW_PD_POS] ?
                           {hwdata[7:6], 12'h000} :
                           {2'h0, hwdata[7:0], hwdata[15:12]};
      end
    end
  end

  // ****************************************
  // Open-drain data level and channel store
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  dacrb_chan_mem u_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .m       (mif.mem)
  );

endmodule : dacrb_top
`default_nettype wire

// [tb/dacrb_chk.sv]
// Port checker of the two-wire readback slave
`timescale 1ns/10ps
`default_nettype none
module dacrb_chk (
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Two-wire bus
  input wire logic        scl_i,
  input wire logic        sda_i,
  input wire logic        sda_o,
  input wire logic        sda_oe
);
  // ****************
  // Bit tracking
  // ****************
  logic       scl_d;
  logic       sda_d;
  logic       first;
  logic [3:0] bits;
  logic [7:0] shift;
  wire        rise_w  = !scl_d && scl_i;
  wire        start_w = scl_d && scl_i && sda_d && !sda_i;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_i;
      sda_d <= sda_i;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      first <= 1'b0;
      bits  <= 4'h0;
      shift <= 8'h00;
    end else if (start_w) begin
      first <= 1'b1;
      bits  <= 4'h0;
    end else if (rise_w && bits == 4'h8) begin
      first <= 1'b0;
      bits  <= 4'h0;
    end else if (rise_w) begin
      bits  <= bits + 4'h1;
      shift <= {shift[6:0], sda_i};
    end
  end

  // ****************
  // Checks
  // ****************
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence start_s;
    scl_i && sda_i ##1 scl_i && !sda_i;
  endsequence
  sequence stop_s;
    scl_i && !sda_i ##1 scl_i && sda_i;
  endsequence
  sequence rise_s;
    !scl_i ##1 scl_i;
  endsequence

  addr_release_a: assert property (start_s |=> !sda_oe [*8])
    else $error("slave drives data line after a start");
  stop_release_a: assert property (stop_s |=> !sda_oe [*8])
    else $error("slave drives data line after a stop");
  bit_hold_a: assert property (rise_s |-> $stable(sda_oe) [*8])
    else $error("slave data bit changes while clock high");
  oe_change_a: assert property ($changed(sda_oe) |-> !scl_i && !$past(scl_i))
    else $error("slave data change not in clock low time");
  foreign_noack_a: assert property (rise_w && bits == 4'h8 && first
    && shift[7:1] != {dacrb_pkg::DEV_ADDR_FIXED, 2'h3} |-> !sda_oe)
    else $error("foreign address or entry code acknowledged");
  open_drain_a: assert property (sda_oe |-> !sda_o)
    else $error("data line driven high");
  zero_wait_a: assert property (hsel && htrans[1] && hready |=> hreadyout && !hresp)
    else $error("register bus wait or error response");
  unmapped_zero_a: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr[7:0] == 8'h10 |=> hrdata == 32'h0)
    else $error("unmapped offset reads nonzero");
endmodule : dacrb_chk
`default_nettype wire

// [tb/dacrb_i2c_master.sv]
// Two-wire bus master model issuing readback sequences
`timescale 1ns/10ps
`default_nettype none
module dacrb_i2c_master (
  // Clock
  input  wire logic hclk,
  // Bus lines
  input  wire logic sda_line,
  output logic      scl,
  output logic      sda_pull
);
  initial begin
    scl      = 1'b1;
    sda_pull = 1'b0;
  end

  task automatic hw(input int n);
    repeat (n) @(posedge hclk);
  endtask : hw

  task automatic put(input logic b, output logic r);
    hw(5);
    sda_pull <= ~b;
    hw(15);
    scl <= 1'b1;
    hw(10);
    r = sda_line;
    hw(10);
    scl <= 1'b0;
  endtask : put

  task automatic start();
    hw(1);
    if (scl === 1'b0) begin
      hw(4);
      sda_pull <= 1'b0;
      hw(15);
      scl <= 1'b1;
      hw(20);
    end
    sda_pull <= 1'b1;
    hw(20);
    scl <= 1'b0;
  endtask : start

  task automatic stop();
    hw(5);
    sda_pull <= 1'b1;
    hw(15);
    scl <= 1'b1;
    hw(20);
    sda_pull <= 1'b0;
    hw(20);
  endtask : stop

  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) put(b[i], r);
    put(1'b1, r);
    ack = ~r;
  endtask : send

  task automatic recv(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) put(1'b1, b[i]);
    put(last, r);
  endtask : recv

  task automatic read_back(input logic [6:0] dev, input logic [7:0] ctrl, input int n,
                           input logic hs, input logic rs, output logic [3:0] ak,
                           output logic [23:0] d);
    logic [7:0] b;
    ak = 4'h0;
    d  = 24'h0;
    if (hs) begin
      start();
      send(8'h0f, ak[3]);
    end
    start();
    send({dev, 1'b0}, ak[2]);
    send(ctrl, ak[1]);
    start();
    send({dev, 1'b1}, ak[0]);
    for (int i = 0; i < n; i++) begin
      recv(i == n - 1, b);
      d = {d[15:0], b};
    end
    if (rs) start();
    stop();
  endtask : read_back
endmodule : dacrb_i2c_master
`default_nettype wire

// [tb/dacrb_tb_top.sv]
// Bench top: register bus tasks and readback scenarios
`timescale 1ns/10ps
`default_nettype none
module dacrb_tb_top;
  logic        hclk;
  logic        hresetn;
  logic        hsel;
  logic        hwrite;
  logic [1:0]  htrans;
  logic [31:0] haddr;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic        hreadyout;
  logic        hresp;
  logic        sda_o;
  logic        sda_oe;
  logic        scl;
  logic        sda_pull;
  logic [3:0]  ak;
  logic [23:0] d;
  logic [11:0] code;
  logic [7:0]  ctrl;
  logic [1:0]  ch;
  logic        pd;
  logic [6:0]  dev;
  wire         hready   = hreadyout;
  wire         sda_line = !(sda_pull || (sda_oe && !sda_o));
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;

  initial begin
    hclk = 1'b0;
    forever #2 hclk = ~hclk;
  end

  dacrb_top dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
  dacrb_i2c_master m_u (.hclk(hclk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_count++;
      $display("ERROR %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  task automatic close_out();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    haddr  <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : ahb

  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 60000) begin
      err_count++;
      close_out();
    end
  end

  // ****************
  // Scenarios
  // ****************
  initial begin
    hresetn = 1'b0;
    hsel    = 1'b0;
    htrans  = 2'h0;
    haddr   = 32'h0;
    hwrite  = 1'b0;
    hwdata  = 32'h0;
    dev     = {dacrb_pkg::DEV_ADDR_FIXED, 2'h3};
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    ahb(1'b0, dacrb_pkg::OFS_CFG, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, dacrb_pkg::OFS_STAT, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, dacrb_pkg::OFS_CHWR, 32'h0);
    chk(rd, 32'h0);
    m_u.read_back(dev, 8'h00, 2, 1'b0, 1'b0, ak, d);
    chk(ak, 32'h0);
    ahb(1'b1, dacrb_pkg::OFS_CFG, 32'h7);
    ahb(1'b1, 8'h10, 32'hffff_ffff);
    ahb(1'b0, 8'h10, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, dacrb_pkg::OFS_CFG, 32'h0);
    chk(rd, 32'h7);
    for (int c = 0; c < 4; c++) begin
      code = 12'(12'h123 * (c + 1));
      ahb(1'b1, dacrb_pkg::OFS_CHWR, {14'h0, 2'(c), code[3:0], 4'h0, code[11:4]});
      ahb(1'b1, dacrb_pkg::OFS_CHWR, {13'h0, 1'b1, 2'(c), 8'h0, 2'(c), 6'h0});
    end
    for (int c = 0; c < 8; c++) begin
      ch   = 2'(c % 4);
      pd   = 1'(c / 4);
      code = 12'(12'h123 * (c % 4 + 1));
      ctrl = {4'h1, 1'b1, ch, pd};
      m_u.read_back(dev, ctrl, 2 + c / 4, c == 5, c == 6, ak, d);
      chk(ak, 32'h7);
      chk(d & 24'hff_fff0, {pd ? {ch, 6'h3f} : 8'h0, code, 4'h0});
      ahb(1'b0, dacrb_pkg::OFS_STAT, 32'h0);
      chk(rd & 32'h0000_ff07, {16'h0, ctrl, 8'h0});
      chk(sda_oe, 32'h0);
    end
    m_u.read_back(7'h4e, 8'h00, 2, 1'b0, 1'b0, ak, d);
    chk(ak, 32'h0);
    close_out();
  end
endmodule : dacrb_tb_top

bind dacrb_top dacrb_chk chk_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .scl_i(scl_i), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe));
`default_nettype wire
